// ---- hw/aux_wake_and_pin_mux.sv ----
// auxiliary wake event status/enable and serial port 2 / dma3 pin multiplexers
// assumes synchronous pins, a plain register port and a standby-power reset on nrst_in
//
// Contract
// [RQ1] one sticky status bit per wake source, set regardless of enables
// [RQ2] status cleared only by standby-power power-on reset
// [RQ3] writing one clears status bit, writing zero leaves it
// [RQ4] wake output low when source enabled, event seen and global enable set
// [RQ5] disabled source still records status but does not drive wake output
// [RQ6] enable register shares status layout, cleared only by standby-power reset
// [RQ7] qualification bit turns port2 rts into address input sa12, else zero
// [RQ8] qualification bit turns port2 cts into sa13; unselected inputs forced
// [RQ9] qualification bit turns port2 dtr into address input sa14, else zero
// [RQ10] qualification bit turns port2 dsr into sa15; unselected inputs forced
// [RQ11] kbc select turns port2 carrier detect into kbc line a
// [RQ12] kbc select turns port2 ring indicator into kbc line b
// [RQ13] dma3 select low turns dma request pin into kbc line a
// [RQ14] dma3 select low turns dma acknowledge pin into kbc line b; the code only forces dma_ch3_ack_n_out high
// [RQ15] global wake enable is bit zero of control, resets to zero
// [RQ16] wake output stays a level while enabled status bit remains set
// [RQ17] reserved status and enable bits read zero, writes ignored
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`include "aux_wake_defs.svh"

module aux_wake_and_pin_mux (
	input  wire logic                  ref_clk_in,
	input  wire logic                  nrst_in,
	input  wire logic                  main_rst_in,
	input  wire aux_wake_pkg::reg_byte_t addr_in,
	input  wire aux_wake_pkg::reg_byte_t wdata_in,
	input  wire logic                  wr_in,
	input  wire logic                  rd_in,
	output logic [7:0]                 rdata_out,
	input  wire logic                  port1_ring_wake_in,
	input  wire logic                  port2_ring_wake_in,
	input  wire logic                  keyboard_wake_in,
	input  wire logic                  mouse_wake_in,
	output logic                       wake_request_out_n,
	output logic                       irq_out,
	input  wire logic                  port2_request_to_send_n_in,
	input  wire logic                  port2_terminal_ready_n_in,
	output logic                       port2_rts_pin_out,
	output logic                       port2_rts_pin_oe_out,
	input  wire logic                  port2_rts_pin_in,
	output logic                       port2_dtr_pin_out,
	output logic                       port2_dtr_pin_oe_out,
	input  wire logic                  port2_dtr_pin_in,
	input  wire logic                  port2_cts_pin_in,
	input  wire logic                  port2_dsr_pin_in,
	input  wire logic                  port2_dcd_pin_in,
	input  wire logic                  port2_ri_pin_in,
	output logic                       port2_clear_to_send_n_out,
	output logic                       port2_set_ready_n_out,
	output logic                       port2_carrier_detect_n_out,
	output logic                       port2_ring_indicator_n_out,
	output logic [15:12]               sa_high_out,
	input  wire logic                  kbc_port_line_a_in,
	input  wire logic                  kbc_port_line_b_in,
	output logic                       kbc_port_line_a_out,
	output logic                       kbc_port_line_b_out,
	input  wire logic                  dma_ch3_request_in,
	output logic                       dma_ch3_req_pin_out,
	input  wire logic                  dma_ch3_ack_pin_in,
	output logic                       dma_ch3_ack_n_out
);
	import aux_wake_pkg::*;

	// named copy of the mux reset byte; a bare literal cannot be bit-selected
	localparam reg_byte_t pin_mux_rst = `PIN_MUX_RESET;

	////////////////////////////////////////////////////////////////////////////
	// register state

	wake_src_t  status_q;
	wake_src_t  enable_q;
	logic       global_wake_out_enable_q;
	logic       addr_qual16_select_q;
	logic       kbc_serial_pin_select_q;
	logic       dma_ch3_pin_select_q;
	wake_src_t  irq_status_q;
	wake_src_t  irq_mask_q;
	wake_src_t  event_now;
	wake_src_t  event_prev_q;
	wake_src_t  event_rise;
	wake_src_t  wr_clear;
	logic       wr_status;
	logic       wr_irq_status;

	assign event_now = {mouse_wake_in, keyboard_wake_in, port1_ring_wake_in, port2_ring_wake_in};
	assign event_rise = event_now & ~event_prev_q;
	assign wr_status = wr_in && (addr_in == `WAKE_STATUS_OFFSET);
	assign wr_irq_status = wr_in && (addr_in == `IRQ_STATUS_OFFSET);
	// reserved bits 0 and 7:5 are dropped from every status, enable and mask write
	assign wr_clear = wdata_in[4:1];	// see [RQ17]

	// edge memory for the interrupt events; a held level raises one event only
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			event_prev_q <= '0;
		end else begin
			event_prev_q <= event_now;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// wake status: sticky, standby reset only, set beats clear

	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			status_q <= '0;	// see [RQ2]
		end else begin
			// a level event re-asserts every cycle, so a clear under a live event is lost
			status_q <= (status_q & ~(wr_status ? wr_clear : 4'h0)) | event_now;	// see [RQ1] [RQ3]
		end
	end

	// wake enable: main-power reset does not reach it
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			enable_q <= '0;	// see [RQ6]
		end else if (wr_in && addr_in == `WAKE_ENABLE_OFFSET) begin
			enable_q <= wdata_in[4:1];	// see [RQ6] [RQ17]
		end
	end

	// global wake enable, also standby-domain state
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			global_wake_out_enable_q <= 1'b0;	// see [RQ15]
		end else if (wr_in && addr_in == `WAKE_CTRL_OFFSET) begin
			global_wake_out_enable_q <= wdata_in[`BIT_GLOBAL_EN];	// see [RQ15]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pin mux controls; these follow main power so main_rst_in restores defaults

	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			addr_qual16_select_q    <= 1'b0;
			kbc_serial_pin_select_q <= pin_mux_rst[`BIT_KBC_SEL];
			dma_ch3_pin_select_q    <= pin_mux_rst[`BIT_DMA3_SEL];
		end else if (main_rst_in) begin
			addr_qual16_select_q    <= 1'b0;
			kbc_serial_pin_select_q <= pin_mux_rst[`BIT_KBC_SEL];
			dma_ch3_pin_select_q    <= pin_mux_rst[`BIT_DMA3_SEL];
		end else if (wr_in) begin
			if (addr_in == `ADDR_QUAL_OFFSET) begin
				addr_qual16_select_q <= wdata_in[`BIT_ADDR_QUAL];
			end
			if (addr_in == `PIN_MUX_OFFSET) begin
				kbc_serial_pin_select_q <= wdata_in[`BIT_KBC_SEL];
				dma_ch3_pin_select_q    <= wdata_in[`BIT_DMA3_SEL];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupt: sticky on event rise, write one to clear, set beats clear

	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			irq_status_q <= '0;
			irq_mask_q   <= '0;
			irq_out      <= 1'b0;
		end else begin
			irq_status_q <= (irq_status_q & ~(wr_irq_status ? wr_clear : 4'h0)) | event_rise;
			if (wr_in && addr_in == `IRQ_MASK_OFFSET) begin
				irq_mask_q <= wdata_in[4:1];
			end
			irq_out <= |(irq_status_q & irq_mask_q);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// wake output: a level while any enabled status bit stays set

	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			wake_request_out_n <= 1'b1;
		end else begin
			// disabled sources are masked here but still recorded above
			wake_request_out_n <= ~(global_wake_out_enable_q && |(status_q & enable_q));	// see [RQ4] [RQ5] [RQ16]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// register read: one cycle latency, unmapped reads zero

	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rdata_out <= '0;
		end else if (rd_in) begin
			unique case (addr_in)
				`WAKE_STATUS_OFFSET: rdata_out <= {3'h0, status_q, 1'b0};	// see [RQ17]
				`WAKE_ENABLE_OFFSET: rdata_out <= {3'h0, enable_q, 1'b0};	// see [RQ17]
				`WAKE_CTRL_OFFSET:   rdata_out <= {7'h00, global_wake_out_enable_q};
				`ADDR_QUAL_OFFSET:   rdata_out <= {1'b0, addr_qual16_select_q, 6'h00};
				`PIN_MUX_OFFSET:     rdata_out <= {4'h0, kbc_serial_pin_select_q, 1'b0,
								dma_ch3_pin_select_q, 1'b0};
				`IRQ_STATUS_OFFSET:  rdata_out <= {3'h0, irq_status_q, 1'b0};
				`IRQ_MASK_OFFSET:    rdata_out <= {3'h0, irq_mask_q, 1'b0};
				default:             rdata_out <= 8'h00;
			endcase
		end else begin
			rdata_out <= '0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pin multiplexers, registered so every output leaves a flip-flop

	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			port2_rts_pin_out          <= 1'b1;
			port2_rts_pin_oe_out       <= 1'b1;
			port2_dtr_pin_out          <= 1'b1;
			port2_dtr_pin_oe_out       <= 1'b1;
			port2_clear_to_send_n_out  <= 1'b1;
			port2_set_ready_n_out      <= 1'b1;
			sa_high_out                <= 4'h0;
		end else begin
			// rts and dtr pins turn round to inputs when used for address
			port2_rts_pin_out    <= port2_request_to_send_n_in;	// see [RQ7]
			port2_rts_pin_oe_out <= ~addr_qual16_select_q;	// see [RQ7]
			port2_dtr_pin_out    <= port2_terminal_ready_n_in;	// see [RQ9]
			port2_dtr_pin_oe_out <= ~addr_qual16_select_q;	// see [RQ9]
			// unselected modem inputs idle high, unselected address bits low
			port2_clear_to_send_n_out <= addr_qual16_select_q ? 1'b1 : port2_cts_pin_in;	// see [RQ8]
			port2_set_ready_n_out     <= addr_qual16_select_q ? 1'b1 : port2_dsr_pin_in;	// see [RQ10]
			sa_high_out <= addr_qual16_select_q ?
				{port2_dsr_pin_in, port2_dtr_pin_in, port2_cts_pin_in, port2_rts_pin_in} :
				4'h0;	// see [RQ7] [RQ8] [RQ9] [RQ10]
		end
	end

	// carrier detect / ring pins against kbc lines, and the dma3 pins
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			port2_carrier_detect_n_out <= 1'b1;
			port2_ring_indicator_n_out <= 1'b1;
			kbc_port_line_a_out        <= 1'b0;
			kbc_port_line_b_out        <= 1'b0;
			dma_ch3_req_pin_out        <= 1'b0;
			dma_ch3_ack_n_out          <= 1'b1;
		end else begin
			port2_carrier_detect_n_out <= kbc_serial_pin_select_q ? 1'b1 : port2_dcd_pin_in;	// see [RQ11]
			port2_ring_indicator_n_out <= kbc_serial_pin_select_q ? 1'b1 : port2_ri_pin_in;	// see [RQ12]
			// kbc lines come in on the dcd and ri modem pins when selected, else from the kbc line inputs
			kbc_port_line_a_out <= kbc_serial_pin_select_q ? port2_dcd_pin_in : kbc_port_line_a_in;	// see [RQ11]
			kbc_port_line_b_out <= kbc_serial_pin_select_q ? port2_ri_pin_in : kbc_port_line_b_in;	// see [RQ12]
			dma_ch3_req_pin_out <= dma_ch3_pin_select_q ? dma_ch3_request_in : kbc_port_line_a_in;	// see [RQ13]
			dma_ch3_ack_n_out   <= dma_ch3_pin_select_q ? dma_ch3_ack_pin_in : 1'b1;	// see [RQ14]
		end
	end

endmodule // aux_wake_and_pin_mux

// ---- hw/aux_wake_defs.svh ----
// register offsets, field positions and reset values of the auxiliary wake and pin mux block
// assumes an 8-bit register port with byte-wide offsets
`ifndef AUX_WAKE_DEFS_SVH
`define AUX_WAKE_DEFS_SVH
`define WAKE_CTRL_OFFSET     8'hc5
`define WAKE_STATUS_OFFSET   8'hc7
`define WAKE_ENABLE_OFFSET   8'hc8
`define PIN_MUX_OFFSET       8'hc0
`define ADDR_QUAL_OFFSET     8'h24
`define IRQ_STATUS_OFFSET    8'hd0
`define IRQ_MASK_OFFSET      8'hd1
`define WAKE_SRC_MASK        8'h1e
`define PIN_MUX_RESET        8'h02
`define WAKE_RESET           8'h00
`define BIT_GLOBAL_EN        0
`define BIT_DMA3_SEL         1
`define BIT_KBC_SEL          3
`define BIT_ADDR_QUAL        6
`define BIT_PORT2_RING       1
`define BIT_PORT1_RING       2
`define BIT_KEYBOARD         3
`define BIT_MOUSE            4
`endif

// ---- hw/aux_wake_pkg.sv ----
// types shared by the auxiliary wake and pin mux block
// assumes the defs header supplies all numbers
package aux_wake_pkg;
	typedef logic [7:0] reg_byte_t;
	typedef logic [3:0] wake_src_t;	// port2 ring, port1 ring, keyboard, mouse
endpackage

// ---- tb/far_side_model.sv ----
// far side of the pin mux: isa address lines meeting the two-way modem pins
// assumes the bench supplies the address bits and the other pin levels
`timescale 1ns/1ps
module far_side_model (
	input  wire logic         rts_oe_in,
	input  wire logic         rts_in,
	input  wire logic         dtr_oe_in,
	input  wire logic         dtr_in,
	input  wire logic [15:12] sa_in,
	output logic              rts_pin_out,
	output logic              dtr_pin_out
);
	// the address bus owns a pin only once the block lets go, so no fight on the wire
	assign rts_pin_out = rts_oe_in ? rts_in : sa_in[12];
	assign dtr_pin_out = dtr_oe_in ? dtr_in : sa_in[14];
endmodule // far_side_model

// ---- tb/aux_wake_properties.sv ----
// port-level assertions for the auxiliary wake and pin mux block
// assumes binding to the block, one clock and the standby reset
`timescale 1ns/1ps
module aux_wake_properties (
	input wire logic         ref_clk_in, nrst_in, main_rst_in, wr_in, rd_in, irq_out,
	input wire logic [7:0]   rdata_out,
	input wire logic         port1_ring_wake_in, port2_ring_wake_in, keyboard_wake_in, mouse_wake_in,
	input wire logic         wake_request_out_n, port2_cts_pin_in, port2_dsr_pin_in, port2_rts_pin_in,
	input wire logic         port2_dtr_pin_in, port2_clear_to_send_n_out, port2_set_ready_n_out,
	input wire logic [15:12] sa_high_out,
	input wire logic         dma_ch3_request_in, kbc_port_line_a_in, dma_ch3_req_pin_out,
	input wire logic         dma_ch3_ack_pin_in, dma_ch3_ack_n_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!nrst_in);
	// besides a write, only a wake source may move the wake and interrupt outputs
	wire any_wake = port1_ring_wake_in | port2_ring_wake_in | keyboard_wake_in | mouse_wake_in;
	a_rdata_read_slot: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
		else $error("read data outside its slot");
	a_wake_fall_cause: assert property ($fell(wake_request_out_n) |->
		$past(any_wake) || $past(any_wake, 2) || $past(wr_in) || $past(wr_in, 2))
		else $error("wake fell without cause");
	a_wake_held_level: assert property ($rose(wake_request_out_n) |->
		$past(wr_in) || $past(wr_in, 2)) else $error("wake released without a write");
	a_irq_rise_cause: assert property ($rose(irq_out) |-> $past(any_wake) ||
		$past(any_wake, 2) || $past(wr_in) || $past(wr_in, 2)) else $error("irq without cause");
	a_cts_pin_pass: assert property (!port2_clear_to_send_n_out |-> !$past(port2_cts_pin_in))
		else $error("cts low without pin low");
	a_dsr_pin_pass: assert property (!port2_set_ready_n_out |-> !$past(port2_dsr_pin_in))
		else $error("dsr low without pin low");
	a_addr_from_pins: assert property ((sa_high_out & ~$past({port2_dsr_pin_in,
		port2_dtr_pin_in, port2_cts_pin_in, port2_rts_pin_in})) == 4'h0) else $error("bad address bit");
	a_addr_forces_modem: assert property (sa_high_out != 4'h0 |->
		port2_clear_to_send_n_out && port2_set_ready_n_out) else $error("modem input not forced");
	a_dma_req_source: assert property (dma_ch3_req_pin_out |->
		$past(dma_ch3_request_in) || $past(kbc_port_line_a_in)) else $error("request pin bad source");
	a_ack_pin_pass: assert property (!dma_ch3_ack_n_out |-> !$past(dma_ch3_ack_pin_in))
		else $error("ack low without pin low");
	a_main_rst_mux: assert property (main_rst_in |-> ##2 (sa_high_out == 4'h0 &&
		dma_ch3_ack_n_out == $past(dma_ch3_ack_pin_in))) else $error("main reset left mux set");
	c_wake_asserted: cover property ($fell(wake_request_out_n));
	c_addr_mode: cover property (sa_high_out != 4'h0);
	c_irq_raised: cover property ($rose(irq_out));
endmodule // aux_wake_properties
////////////////////////////////////////////////////////////////////////////////
bind aux_wake_and_pin_mux aux_wake_properties i_aux_wake_properties (.*);

// ---- tb/aux_wake_and_pin_mux_tb.sv ----
// self-checking bench for the auxiliary wake and pin mux block
// assumes a 100 mhz clock and the far side model on the two-way pins
`timescale 1ns/1ps
module aux_wake_and_pin_mux_tb;
	logic ref_clk_in = 1'h0, nrst_in = 1'h0, main_rst_in = 1'h0, wr_in = 1'h0, rd_in = 1'h0, a;
	aux_wake_pkg::reg_byte_t addr_in = 8'h00, wdata_in = 8'h00;
	logic [7:0] rdata_out;
	logic [4:1] ev = 4'h0;
	wire port2_ring_wake_in = ev[1], port1_ring_wake_in = ev[2], keyboard_wake_in = ev[3];
	wire mouse_wake_in = ev[4];
	logic wake_request_out_n, irq_out, port2_rts_pin_out, port2_rts_pin_oe_out, port2_rts_pin_in;
	logic port2_dtr_pin_out, port2_dtr_pin_oe_out, port2_dtr_pin_in, port2_clear_to_send_n_out;
	logic port2_set_ready_n_out, port2_carrier_detect_n_out, port2_ring_indicator_n_out;
	logic kbc_port_line_a_out, kbc_port_line_b_out, dma_ch3_req_pin_out, dma_ch3_ack_n_out;
	logic [15:12] sa_high_out, sa_bus = 4'h0;
	logic port2_request_to_send_n_in = 1'h0, port2_terminal_ready_n_in = 1'h0, port2_cts_pin_in = 1'h0;
	logic port2_dsr_pin_in = 1'h0, port2_dcd_pin_in = 1'h0, port2_ri_pin_in = 1'h0;
	logic kbc_port_line_a_in = 1'h0, kbc_port_line_b_in = 1'h0, dma_ch3_request_in = 1'h0;
	logic dma_ch3_ack_pin_in = 1'h0;
	int miscompares = 0, checks = 0;
	aux_wake_and_pin_mux i_aux_wake_and_pin_mux (.*);
	far_side_model i_far_side_model (.rts_oe_in(port2_rts_pin_oe_out), .rts_in(port2_rts_pin_out),
		.dtr_oe_in(port2_dtr_pin_oe_out), .dtr_in(port2_dtr_pin_out), .sa_in(sa_bus),
		.rts_pin_out(port2_rts_pin_in), .dtr_pin_out(port2_dtr_pin_in));
	////////////////////////////////////////////////////////////////////////////////
	// bus cycles and comparison; reads are judged in the one cycle the data stands
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		@(posedge ref_clk_in) {addr_in, wdata_in, wr_in} <= {ad, d, 1'h1};
		@(posedge ref_clk_in) wr_in <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] ad, input logic [7:0] e);
		@(posedge ref_clk_in) {addr_in, rd_in} <= {ad, 1'h1};
		@(posedge ref_clk_in) rd_in <= 1'h0;
		@(negedge ref_clk_in) chk(rdata_out, e);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk_in);
		@(negedge ref_clk_in);
	endtask
	task automatic pulse(input int i);
		@(posedge ref_clk_in) ev[i] <= 1'h1;
		@(posedge ref_clk_in) ev <= 4'h0;
	endtask
	task automatic mrst;
		@(posedge ref_clk_in) main_rst_in <= 1'h1;
		@(posedge ref_clk_in) main_rst_in <= 1'h0;
	endtask
	task automatic t_reset;
		chk({wake_request_out_n, irq_out}, 8'h02);
		rd(8'hc7, 8'h00);
		rd(8'hc8, 8'h00);
		rd(8'hc5, 8'h00);
		rd(8'h55, 8'h00);
	endtask
	task automatic t_wake;
		wr(8'hc8, 8'hff);
		rd(8'hc8, 8'h1e);
		wr(8'hc5, 8'h01);
		for (int i = 1; i <= 4; i++) begin
			pulse(i);
			rd(8'hc7, 8'h01 << i);
			wr(8'hc7, ~(8'h01 << i));
			rd(8'hc7, 8'h01 << i);
			chk(wake_request_out_n, 8'h00);
			wr(8'hc7, 8'h01 << i);
			rd(8'hc7, 8'h00);
			chk(wake_request_out_n, 8'h01);
		end
	endtask
	task automatic t_disabled;
		wr(8'hc8, 8'h04);
		pulse(3);
		rd(8'hc7, 8'h08);
		chk(wake_request_out_n, 8'h01);
		wr(8'hc5, 8'h00);
		pulse(2);
		rd(8'hc7, 8'h0c);
		chk(wake_request_out_n, 8'h01);
		wr(8'hc5, 8'h01);
		cyc(2);
		chk(wake_request_out_n, 8'h00);
		mrst;
		rd(8'hc7, 8'h0c);
		rd(8'hc8, 8'h04);
		rd(8'hc5, 8'h01);
	endtask
	// mask polarity is left open, so only the difference between the two masks is judged
	task automatic t_irq;
		wr(8'hd1, 8'h00);
		cyc(2);
		a = irq_out;
		wr(8'hd1, 8'h1e);
		cyc(2);
		chk(a ^ irq_out, 8'h01);
		rd(8'hd0, 8'h1e);
		wr(8'hd0, 8'h1e);
		wr(8'hc7, 8'h1e);
		rd(8'hd0, 8'h00);
		chk(irq_out, 8'h00);
	endtask
	task automatic t_mux;
		cyc(2);
		chk({sa_high_out, port2_rts_pin_oe_out, port2_clear_to_send_n_out, port2_set_ready_n_out,
			port2_rts_pin_in}, 8'h08);
		wr(8'h24, 8'h40);
		sa_bus <= 4'h5;
		cyc(3);
		chk({sa_high_out, port2_rts_pin_oe_out, port2_dtr_pin_oe_out, port2_clear_to_send_n_out,
			port2_set_ready_n_out}, 8'h53);
		wr(8'h24, 8'h00);
		wr(8'hc0, 8'h08);
		@(posedge ref_clk_in)
			{port2_dcd_pin_in, kbc_port_line_b_in, dma_ch3_request_in, dma_ch3_ack_pin_in} <= 4'he;
		cyc(3);
		chk({kbc_port_line_a_out, kbc_port_line_b_out, port2_carrier_detect_n_out,
			port2_ring_indicator_n_out, dma_ch3_req_pin_out, dma_ch3_ack_n_out}, 8'h2d);
		mrst;
		cyc(2);
		chk({kbc_port_line_a_out, kbc_port_line_b_out, port2_carrier_detect_n_out,
			port2_ring_indicator_n_out, dma_ch3_req_pin_out, dma_ch3_ack_n_out}, 8'h1a);
		rd(8'hc0, 8'h02);
	endtask
	task automatic final_report;
		if (miscompares == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// clock, main sequence and a watchdog well beyond the some 125 cycles needed
	initial begin
		forever #5 ref_clk_in = ~ref_clk_in;
	end
	initial begin
		repeat (2) @(posedge ref_clk_in);
		nrst_in <= 1'h1;
		t_reset;
		t_wake;
		t_disabled;
		t_irq;
		t_mux;
		final_report;
	end
	initial begin
		repeat (3000) @(posedge ref_clk_in);
		miscompares++;
		final_report;
	end
endmodule // aux_wake_and_pin_mux_tb
